//--- clsd_map.vh
`ifndef CLSD_MAP_VH
`define CLSD_MAP_VH

// Opcode groups, top bits of the 16-bit instruction
`define CLSD_GRP4_MSB 15
`define CLSD_GRP4_LSB 12
`define CLSD_GRP3_LSB 13
`define CLSD_GRP_REGOFF 4'h5
`define CLSD_GRP_IMM_WB 3'h3
`define CLSD_GRP_IMM_HALF 4'h8
`define CLSD_GRP_SP_REL 4'h9
`define CLSD_GRP_ADDR_GEN 4'hA

// Register-offset group: bit 9 high selects the sign-extended/halfword forms
`define CLSD_REGOFF_EXT_BIT 9
`define CLSD_REGOFF_LOAD_BIT 10
`define CLSD_REGOFF_BYTE_BIT 11

// Immediate, stack and address generation groups
`define CLSD_IMM_BYTE_BIT 12
`define CLSD_LOAD_BIT 11
`define CLSD_ADDR_SEL_BIT 11

// Register and offset fields
`define CLSD_RD_MSB 2
`define CLSD_RD_LSB 0
`define CLSD_RB_MSB 5
`define CLSD_RB_LSB 3
`define CLSD_RO_MSB 8
`define CLSD_RO_LSB 6
`define CLSD_OFF5_MSB 10
`define CLSD_OFF5_LSB 6
`define CLSD_RD_HI_MSB 10
`define CLSD_RD_HI_LSB 8
`define CLSD_EIGHT_BIT_WORD_OFFSET_FIELD_MSB 7
`define CLSD_EIGHT_BIT_WORD_OFFSET_FIELD_LSB 0

// Transfer sizes
`define CLSD_SIZE_BYTE 2'h0
`define CLSD_SIZE_HALF 2'h1
`define CLSD_SIZE_WORD 2'h2

// Program counter base
`define CLSD_PC_AHEAD 32'h00000004
`define CLSD_PC_ALIGN_MASK 32'hFFFFFFFD

// Reset values
`define CLSD_RST_WORD 32'h00000000
`define CLSD_RST_REG 3'h0
`define CLSD_RST_SIZE 2'h0

`endif

//--- clsd_load_extend.v
`timescale 1ns/1ps
`include "clsd_map.vh"

module clsd_load_extend #(
  parameter WIDTH = 32
) (
  input wire mclk_in, // Core clock
  input wire resetn_in, // Async reset, active low
  input wire capture_in, // Take read data this cycle
  input wire [1:0] size_in, // Transfer size
  input wire signed_in, // Sign-extend result
  input wire [WIDTH-1:0] data_in, // Read data, lane in low bits
  output reg [WIDTH-1:0] data_out // Extended result
);

  reg [WIDTH-1:0] next_data;

  // Zero or sign extension by size
  always @* begin
    next_data = data_in;
    case (size_in)
      `CLSD_SIZE_BYTE: begin
        if (signed_in) begin
          next_data = {{(WIDTH-8){data_in[7]}}, data_in[7:0]};
        end else begin
          next_data = {{(WIDTH-8){1'b0}}, data_in[7:0]};
        end
      end
      `CLSD_SIZE_HALF: begin
        if (signed_in) begin
          next_data = {{(WIDTH-16){data_in[15]}}, data_in[15:0]};
        end else begin
          next_data = {{(WIDTH-16){1'b0}}, data_in[15:0]};
        end
      end
      default: begin
        next_data = data_in;
      end
    endcase
  end

  // Result register
  always @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      data_out <= {WIDTH{1'b0}};
    end else if (capture_in) begin
      data_out <= next_data;
    end
  end

endmodule

//--- clsd_decode.v
// Functional notes
// - Halfword store to base plus offset register
// - Unsigned halfword load clears upper bits
// - Signed byte load copies bit seven
// - Signed halfword load copies bit fifteen
// - Word immediate offset scaled by four
// - Immediate word store writes full register
// - Immediate word load reads full word
// - Immediate byte store, unscaled offset
// - Immediate byte load, unscaled offset
// - Halfword immediate offset scaled by two
// - Immediate halfword store writes low half
// - Immediate halfword load zeroes upper half
// - Stack offset is word count times four
// - Stack transfer: load or store word
// - Select zero adds constant to PC
// - Select one adds constant to SP
// - Cycle counts match full-width equivalents
// - PC base is address plus four, bit1 cleared
// - Address generation never touches flags
`timescale 1ns/1ps
`include "clsd_map.vh"

module clsd_decode #(
  parameter DATA_W = 32,
  parameter REG_W = 3
) (
  input wire mclk_in, // Core clock, 40 MHz
  input wire resetn_in, // Async reset, active low
  input wire instr_valid_in, // Instruction offered
  input wire [15:0] instr_in, // Compact instruction word
  input wire [DATA_W-1:0] instr_addr_in, // Address of this instruction
  output wire instr_ready_out, // Instruction may be taken
  output wire instr_reject_out, // Offered word is not handled here
  output wire busy_out, // Instruction in progress
  output wire [REG_W-1:0] rf_base_sel_out, // Base register read select
  input wire [DATA_W-1:0] rf_base_in, // Base register value
  output wire [REG_W-1:0] rf_offset_sel_out, // Offset register read select
  input wire [DATA_W-1:0] rf_offset_in, // Offset register value
  output wire [REG_W-1:0] rf_data_sel_out, // Store data register read select
  input wire [DATA_W-1:0] rf_data_in, // Store data register value
  input wire [DATA_W-1:0] sp_in, // Stack pointer value
  output reg rf_we_out, // Register write pulse
  output reg [REG_W-1:0] rf_waddr_out, // Register write select
  output reg [DATA_W-1:0] rf_wdata_out, // Register write data
  output reg flag_we_out, // Condition flag write, held low
  output reg mem_req_out, // Memory access request
  output reg mem_we_out, // Memory write
  output reg [1:0] mem_size_out, // Byte, halfword or word
  output reg [DATA_W-1:0] mem_addr_out, // Memory byte address
  output reg [DATA_W-1:0] mem_wdata_out, // Store data, lane in low bits
  input wire mem_ready_in, // Memory access completes
  input wire [DATA_W-1:0] mem_rdata_in // Read data, lane in low bits
);

  localparam ST_IDLE = 2'h0;
  localparam ST_MEM = 2'h1;
  localparam ST_WB = 2'h2;

  reg [1:0] state;
  reg [1:0] next_state;

  // Latched transfer attributes
  reg is_load;
  reg is_signed;
  reg [REG_W-1:0] dest;

  // Decode results of the offered word
  reg dec_ours;
  reg dec_mem;
  reg dec_load;
  reg dec_signed;
  reg [1:0] dec_size;
  reg [DATA_W-1:0] dec_base;
  reg [DATA_W-1:0] dec_offset;
  reg [DATA_W-1:0] dec_addr;
  reg [DATA_W-1:0] dec_wdata;
  reg [REG_W-1:0] dec_dest;
  reg [REG_W-1:0] dec_data_sel;

  wire [3:0] grp4;
  wire [2:0] grp3;
  wire [4:0] off5;
  wire [7:0] eight_bit_word_offset_field;
  wire [DATA_W-1:0] pc_base;
  wire [DATA_W-1:0] load_result;
  wire accept;
  wire capture;

  // Format hits and select bits
  wire regoff_hit;
  wire imm_wb_hit;
  wire imm_half_hit;
  wire sp_hit;
  wire addr_gen_hit;
  wire regoff_load_sel;
  wire regoff_byte_sel;
  wire imm_load_sel;
  wire imm_byte_sel;

  // Named operations of the memory formats
  wire store_half_op;
  wire load_half_unsigned_op;
  wire load_byte_signed_op;
  wire load_half_signed_op;
  wire store_word_op;
  wire load_word_op;
  wire store_byte_op;
  wire load_byte_unsigned_op;

  // Instruction fields
  assign grp4 = instr_in[`CLSD_GRP4_MSB:`CLSD_GRP4_LSB];
  assign grp3 = instr_in[`CLSD_GRP4_MSB:`CLSD_GRP3_LSB];
  assign off5 = instr_in[`CLSD_OFF5_MSB:`CLSD_OFF5_LSB];
  assign eight_bit_word_offset_field = instr_in[`CLSD_EIGHT_BIT_WORD_OFFSET_FIELD_MSB:`CLSD_EIGHT_BIT_WORD_OFFSET_FIELD_LSB];

  // Which of the five formats the offered word belongs to
  assign regoff_hit = (grp4 == `CLSD_GRP_REGOFF) && instr_in[`CLSD_REGOFF_EXT_BIT];
  assign imm_wb_hit = (grp3 == `CLSD_GRP_IMM_WB);
  assign imm_half_hit = (grp4 == `CLSD_GRP_IMM_HALF);
  assign sp_hit = (grp4 == `CLSD_GRP_SP_REL);
  assign addr_gen_hit = (grp4 == `CLSD_GRP_ADDR_GEN);
  assign regoff_load_sel = instr_in[`CLSD_REGOFF_LOAD_BIT];
  assign regoff_byte_sel = instr_in[`CLSD_REGOFF_BYTE_BIT];
  assign imm_load_sel = instr_in[`CLSD_LOAD_BIT];
  assign imm_byte_sel = instr_in[`CLSD_IMM_BYTE_BIT];

  // Operation flags shared by the formats that carry them
  assign store_half_op = (regoff_hit && !regoff_load_sel && !regoff_byte_sel) ||
    (imm_half_hit && !imm_load_sel);
  assign load_half_unsigned_op = (regoff_hit && !regoff_load_sel && regoff_byte_sel) ||
    (imm_half_hit && imm_load_sel);
  assign load_byte_signed_op = regoff_hit && regoff_load_sel && !regoff_byte_sel;
  assign load_half_signed_op = regoff_hit && regoff_load_sel && regoff_byte_sel;
  assign store_word_op = (imm_wb_hit && !imm_byte_sel && !imm_load_sel) ||
    (sp_hit && !imm_load_sel);
  assign load_word_op = (imm_wb_hit && !imm_byte_sel && imm_load_sel) ||
    (sp_hit && imm_load_sel);
  assign store_byte_op = imm_wb_hit && imm_byte_sel && !imm_load_sel;
  assign load_byte_unsigned_op = imm_wb_hit && imm_byte_sel && imm_load_sel;

  // PC seen as instruction address plus four, bit 1 forced low
  assign pc_base = (instr_addr_in + `CLSD_PC_AHEAD) & `CLSD_PC_ALIGN_MASK;

  // Three-bit selects of the low registers
  assign rf_base_sel_out = instr_in[`CLSD_RB_MSB:`CLSD_RB_LSB];
  assign rf_offset_sel_out = instr_in[`CLSD_RO_MSB:`CLSD_RO_LSB];
  assign rf_data_sel_out = dec_data_sel;

  // Handshake
  assign instr_ready_out = (state == ST_IDLE);
  assign accept = instr_ready_out && instr_valid_in && dec_ours;
  assign instr_reject_out = instr_ready_out && instr_valid_in && !dec_ours;
  assign busy_out = (state != ST_IDLE);
  assign capture = (state == ST_MEM) && mem_ready_in && is_load;

  // Format decode, offset scaling and base selection
  always @* begin
    dec_ours = 1'b0;
    dec_mem = 1'b0;
    dec_load = 1'b0;
    dec_signed = 1'b0;
    dec_size = `CLSD_SIZE_WORD;
    dec_base = rf_base_in;
    dec_offset = {DATA_W{1'b0}};
    dec_dest = instr_in[`CLSD_RD_MSB:`CLSD_RD_LSB];
    dec_data_sel = instr_in[`CLSD_RD_MSB:`CLSD_RD_LSB];
    if (regoff_hit) begin
      // Register offset: halfword store, extended loads
      dec_ours = 1'b1;
      dec_mem = 1'b1;
      dec_offset = rf_offset_in;
      case ({instr_in[`CLSD_REGOFF_LOAD_BIT], instr_in[`CLSD_REGOFF_BYTE_BIT]})
        2'h0: begin
          dec_size = `CLSD_SIZE_HALF;
        end
        2'h1: begin
          dec_load = 1'b1;
          dec_size = `CLSD_SIZE_HALF;
        end
        2'h2: begin
          dec_load = 1'b1;
          dec_signed = load_byte_signed_op;
          dec_size = `CLSD_SIZE_BYTE;
        end
        default: begin
          dec_load = 1'b1;
          dec_signed = load_half_signed_op;
          dec_size = `CLSD_SIZE_HALF;
        end
      endcase
    end else if (imm_wb_hit) begin
      // Immediate offset: word scaled by four, byte unscaled
      dec_ours = 1'b1;
      dec_mem = 1'b1;
      dec_load = load_word_op || load_byte_unsigned_op;
      if (imm_byte_sel) begin
        dec_size = `CLSD_SIZE_BYTE;
        dec_offset = {{(DATA_W-5){1'b0}}, off5};
      end else begin
        dec_size = `CLSD_SIZE_WORD;
        dec_offset = {{(DATA_W-7){1'b0}}, off5, 2'h0};
      end
    end else if (imm_half_hit) begin
      // Immediate halfword, offset scaled by two
      dec_ours = 1'b1;
      dec_mem = 1'b1;
      dec_load = load_half_unsigned_op;
      dec_size = `CLSD_SIZE_HALF;
      dec_offset = {{(DATA_W-6){1'b0}}, off5, 1'b0};
    end else if (sp_hit) begin
      // Stack relative word transfer
      dec_ours = 1'b1;
      dec_mem = 1'b1;
      dec_load = load_word_op;
      dec_size = `CLSD_SIZE_WORD;
      dec_base = sp_in;
      dec_offset = {{(DATA_W-10){1'b0}}, eight_bit_word_offset_field, 2'h0};
      dec_dest = instr_in[`CLSD_RD_HI_MSB:`CLSD_RD_HI_LSB];
      dec_data_sel = instr_in[`CLSD_RD_HI_MSB:`CLSD_RD_HI_LSB];
    end else if (addr_gen_hit) begin
      // Address generation from PC or SP
      dec_ours = 1'b1;
      dec_offset = {{(DATA_W-10){1'b0}}, eight_bit_word_offset_field, 2'h0};
      dec_dest = instr_in[`CLSD_RD_HI_MSB:`CLSD_RD_HI_LSB];
      dec_data_sel = instr_in[`CLSD_RD_HI_MSB:`CLSD_RD_HI_LSB];
      if (instr_in[`CLSD_ADDR_SEL_BIT]) begin
        dec_base = sp_in;
      end else begin
        dec_base = pc_base;
      end
    end
    dec_addr = dec_base + dec_offset;
  end

  // Store data placed in the low lanes by size
  always @* begin
    case (dec_size)
      `CLSD_SIZE_BYTE: begin
        dec_wdata = {{(DATA_W-8){1'b0}}, rf_data_in[7:0]};
      end
      `CLSD_SIZE_HALF: begin
        dec_wdata = {{(DATA_W-16){1'b0}}, rf_data_in[15:0]};
      end
      default: begin
        dec_wdata = rf_data_in;
      end
    endcase
  end

  // Sequencing: one, two or three cycles as the full-width forms
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (accept && dec_mem) begin
          next_state = ST_MEM;
        end
      end
      ST_MEM: begin
        if (mem_ready_in) begin
          if (is_load) begin
            next_state = ST_WB;
          end else begin
            next_state = ST_IDLE;
          end
        end
      end
      ST_WB: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // State and latched attributes
  always @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state <= ST_IDLE;
      is_load <= 1'b0;
      is_signed <= 1'b0;
      dest <= `CLSD_RST_REG;
    end else begin
      state <= next_state;
      if (accept) begin
        is_load <= dec_load;
        is_signed <= dec_signed;
        dest <= dec_dest;
      end
    end
  end

  // Memory request, held until the memory completes
  always @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mem_req_out <= 1'b0;
      mem_we_out <= 1'b0;
      mem_size_out <= `CLSD_RST_SIZE;
      mem_addr_out <= `CLSD_RST_WORD;
      mem_wdata_out <= `CLSD_RST_WORD;
    end else if (accept && dec_mem) begin
      mem_req_out <= 1'b1;
      mem_we_out <= store_half_op || store_word_op || store_byte_op;
      mem_size_out <= dec_size;
      mem_addr_out <= dec_addr;
      mem_wdata_out <= dec_wdata;
    end else if (state == ST_MEM && mem_ready_in) begin
      mem_req_out <= 1'b0;
      mem_we_out <= 1'b0;
    end
  end

  // Load result extension
  clsd_load_extend #(
    .WIDTH(DATA_W)
  ) u_extend (
    .mclk_in(mclk_in),
    .resetn_in(resetn_in),
    .capture_in(capture),
    .size_in(mem_size_out),
    .signed_in(is_signed),
    .data_in(mem_rdata_in),
    .data_out(load_result)
  );

  // Register write: address sum at once, loads after the internal cycle
  always @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rf_we_out <= 1'b0;
      rf_waddr_out <= `CLSD_RST_REG;
      rf_wdata_out <= `CLSD_RST_WORD;
    end else if (accept && !dec_mem) begin
      rf_we_out <= 1'b1;
      rf_waddr_out <= dec_dest;
      rf_wdata_out <= dec_addr;
    end else if (state == ST_WB) begin
      rf_we_out <= 1'b1;
      rf_waddr_out <= dest;
      rf_wdata_out <= load_result;
    end else begin
      rf_we_out <= 1'b0;
    end
  end

  // Flags are never written by these formats
  always @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      flag_we_out <= 1'b0;
    end else begin
      flag_we_out <= 1'b0;
    end
  end

endmodule

//--- clsd_decode_assertions.sv
`timescale 1ns/1ps
module clsd_chk (
  input wire mclk_in, // Clock
  input wire resetn_in, // Reset
  input wire instr_valid_in, // Offer
  input wire [15:0] instr_in, // Word
  input wire [31:0] instr_addr_in, // Word address
  input wire instr_ready_out, // Idle
  input wire [31:0] rf_base_in, // Base
  input wire [31:0] rf_data_in, // Data
  input wire [31:0] sp_in, // Stack
  input wire rf_we_out, // Write
  input wire [2:0] rf_waddr_out, // Write select
  input wire [31:0] rf_wdata_out, // Write value
  input wire flag_we_out, // Flags
  input wire mem_req_out, // Request
  input wire mem_we_out, // Store
  input wire [1:0] mem_size_out, // Size
  input wire [31:0] mem_addr_out, // Address
  input wire [31:0] mem_wdata_out, // Store data
  input wire mem_ready_in // Done
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  // Fields of the offered word
  wire tk = instr_valid_in && instr_ready_out;
  wire [4:0] top = instr_in[15:11];
  wire [4:0] o5 = instr_in[10:6];
  wire [7:0] w8 = instr_in[7:0];
  wire [2:0] rdh = instr_in[10:8];
  wire [15:0] d16 = rf_data_in[15:0];
  wire [31:0] pcb = (instr_addr_in + 32'h00000004) & 32'hFFFFFFFD;
  // Steps of a load
  sequence s_ld_done;
    mem_req_out && !mem_we_out && mem_ready_in;
  endsequence
  sequence s_hl_take;
    tk && top == 5'h11;
  endsequence
  AST_FLAGS_QUIET: assert property (!flag_we_out)
    else $error("flag write seen");
  AST_AG_PC: assert property (tk && top == 5'h14 |=> rf_we_out &&
    rf_waddr_out == $past(rdh) && rf_wdata_out == $past(pcb) + {$past(w8), 2'h0})
    else $error("pc sum wrong");
  AST_AG_SP: assert property (tk && top == 5'h15 |=> rf_we_out &&
    rf_waddr_out == $past(rdh) && rf_wdata_out == $past(sp_in) + {$past(w8), 2'h0})
    else $error("sp sum wrong");
  AST_SP_ST: assert property (tk && top == 5'h12 |=> mem_req_out && mem_we_out &&
    mem_size_out == 2'h2 && mem_addr_out == $past(sp_in) + {$past(w8), 2'h0})
    else $error("stack store wrong");
  AST_IMM_W: assert property (tk && top == 5'h0C |=> mem_we_out &&
    mem_addr_out == $past(rf_base_in) + {$past(o5), 2'h0} && mem_wdata_out == $past(rf_data_in))
    else $error("word store wrong");
  AST_HALF_ST: assert property (tk && top == 5'h10 |=> mem_size_out == 2'h1 &&
    mem_addr_out == $past(rf_base_in) + {$past(o5), 1'h0} && mem_wdata_out == {16'h0000, $past(d16)})
    else $error("half store wrong");
  AST_LD_WB: assert property (s_ld_done |-> ##2 rf_we_out)
    else $error("load write late");
  AST_HL_ZERO: assert property (s_hl_take |-> ##[3:8] (rf_we_out && rf_wdata_out[31:16] == 16'h0000))
    else $error("half load upper bits");
endmodule
bind clsd_decode clsd_chk u_chk (.mclk_in(mclk_in), .resetn_in(resetn_in),
  .instr_valid_in(instr_valid_in), .instr_in(instr_in), .instr_addr_in(instr_addr_in),
  .instr_ready_out(instr_ready_out), .rf_base_in(rf_base_in), .rf_data_in(rf_data_in),
  .sp_in(sp_in), .rf_we_out(rf_we_out), .rf_waddr_out(rf_waddr_out),
  .rf_wdata_out(rf_wdata_out), .flag_we_out(flag_we_out), .mem_req_out(mem_req_out),
  .mem_we_out(mem_we_out), .mem_size_out(mem_size_out), .mem_addr_out(mem_addr_out),
  .mem_wdata_out(mem_wdata_out), .mem_ready_in(mem_ready_in));

//--- clsd_partner.sv
`timescale 1ns/1ps
module clsd_partner (
  input wire mclk_in, // Clock
  input wire [2:0] base_sel_in, // Base select
  input wire [2:0] offset_sel_in, // Offset select
  input wire [2:0] data_sel_in, // Data select
  input wire we_in, // Register write
  input wire [2:0] waddr_in, // Write select
  input wire [31:0] wdata_in, // Write value
  input wire req_in, // Access request
  input wire [31:0] addr_in, // Byte address
  output wire [31:0] base_out, // Base value
  output wire [31:0] offset_out, // Offset value
  output wire [31:0] data_out, // Data value
  output wire ready_out, // Access done
  output wire [31:0] rdata_out // Read data
);
  reg [31:0] regs [0:7];
  reg [1:0] cnt;
  // Lane data from the address; upper bits are junk, zero only when a[15:0] is 16'hC3A5
  function automatic [31:0] pat(input [31:0] a);
    pat = {a[15:0] ^ 16'hC3A5, ~a[15:0]};
  endfunction
  // Register reads
  assign base_out = regs[base_sel_in];
  assign offset_out = regs[offset_sel_in];
  assign data_out = regs[data_sel_in];
  // Done at once or after up to three waits; bus shows junk otherwise
  assign ready_out = req_in && cnt == 2'h0;
  assign rdata_out = ready_out ? pat(addr_in) : ~pat(addr_in);
  // Write port and wait counter
  always @(posedge mclk_in) begin
    if (we_in) regs[waddr_in] <= wdata_in;
    if (!req_in) cnt <= 2'($urandom);
    else if (cnt != 2'h0) cnt <= cnt - 2'h1;
  end
endmodule

//--- test_compact_isa_load_store_decode.sv
`timescale 1ns/1ps
module test_compact_isa_load_store_decode;
  reg mclk_in = 1'b0;
  reg resetn_in = 1'b0;
  reg instr_valid_in = 1'b0;
  reg [15:0] instr_in = 16'h0000;
  reg [31:0] instr_addr_in = 32'h00000000;
  reg [31:0] sp_in = 32'h00000000;
  wire instr_ready_out, instr_reject_out, busy_out, rf_we_out, flag_we_out;
  wire mem_req_out, mem_we_out, mem_ready_in;
  wire [2:0] rf_base_sel_out, rf_offset_sel_out, rf_data_sel_out, rf_waddr_out;
  wire [1:0] mem_size_out;
  wire [31:0] rf_base_in, rf_offset_in, rf_data_in, rf_wdata_out;
  wire [31:0] mem_addr_out, mem_wdata_out, mem_rdata_in;
  reg [31:0] rg [0:7];
  reg [34:0] rq [$];
  reg [66:0] mq [$];
  integer mismatches = 0, comparisons = 0, i, x;
  clsd_decode dut (.mclk_in(mclk_in), .resetn_in(resetn_in), .instr_valid_in(instr_valid_in),
    .instr_in(instr_in), .instr_addr_in(instr_addr_in), .instr_ready_out(instr_ready_out),
    .instr_reject_out(instr_reject_out), .busy_out(busy_out),
    .rf_base_sel_out(rf_base_sel_out), .rf_base_in(rf_base_in),
    .rf_offset_sel_out(rf_offset_sel_out), .rf_offset_in(rf_offset_in),
    .rf_data_sel_out(rf_data_sel_out), .rf_data_in(rf_data_in), .sp_in(sp_in),
    .rf_we_out(rf_we_out), .rf_waddr_out(rf_waddr_out), .rf_wdata_out(rf_wdata_out),
    .flag_we_out(flag_we_out), .mem_req_out(mem_req_out), .mem_we_out(mem_we_out),
    .mem_size_out(mem_size_out), .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out),
    .mem_ready_in(mem_ready_in), .mem_rdata_in(mem_rdata_in));
  clsd_partner u_pt (.mclk_in(mclk_in), .base_sel_in(rf_base_sel_out),
    .offset_sel_in(rf_offset_sel_out), .data_sel_in(rf_data_sel_out), .we_in(rf_we_out),
    .waddr_in(rf_waddr_out), .wdata_in(rf_wdata_out), .req_in(mem_req_out),
    .addr_in(mem_addr_out), .base_out(rf_base_in), .offset_out(rf_offset_in),
    .data_out(rf_data_in), .ready_out(mem_ready_in), .rdata_out(mem_rdata_in));
  always #12.5 mclk_in = ~mclk_in;
  task fail(input string m);
    mismatches = mismatches + 1;
    $display("mismatch at %0t: %s", $time, m);
  endtask
  task chk1(input b, input string m);
    comparisons = comparisons + 1;
    if (b !== 1'b1) fail(m);
  endtask
  // Result watcher, oldest note first
  always @(negedge mclk_in) begin
    if (resetn_in && rf_we_out) begin
      if (rq.size() == 0) fail("extra write");
      else chk1({rf_waddr_out, rf_wdata_out} === rq.pop_front(), "write");
    end
    if (resetn_in && mem_req_out && mem_ready_in) begin
      if (mq.size() == 0) fail("extra access");
      else chk_mem(mq.pop_front());
    end
  end
  task chk_mem(input [66:0] e);
    chk1({mem_we_out, mem_size_out, mem_addr_out} === e[66:32] &&
      (!e[66] || mem_wdata_out === e[31:0]), "access");
  endtask
  function automatic [31:0] ext(input [31:0] m, input [2:0] e);
    case (e)
      3'h0: ext = {24'h000000, m[7:0]};
      3'h1: ext = {16'h0000, m[15:0]};
      3'h3: ext = {{24{m[7]}}, m[7:0]};
      3'h4: ext = {{16{m[15]}}, m[15:0]};
      default: ext = m;
    endcase
  endfunction
  task issue(input [15:0] w, input hold);
    instr_valid_in <= 1'b1;
    instr_in <= w;
    @(negedge mclk_in);
    while (!instr_ready_out) @(negedge mclk_in);
    @(posedge mclk_in);
    if (!hold) begin
      instr_valid_in <= 1'b0;
      @(negedge mclk_in);
      while (busy_out) @(negedge mclk_in);
      @(posedge mclk_in);
    end
  endtask
  task run(input [3:0] op, input mx, input hold);
    reg [2:0] rd, rb, ro, e;
    reg [4:0] o5;
    reg [7:0] w8;
    reg [31:0] a, d, r, sv, pc;
    reg [15:0] w;
    reg [1:0] sz;
    reg st;
    {rd, rb, ro, o5, w8} = 22'($urandom);
    if (mx) {o5, w8} = 13'h1FFF;
    sv = $urandom;
    pc = $urandom & 32'hFFFFFFFE;
    sp_in <= sv;
    instr_addr_in <= pc;
    d = rg[rd];
    st = !op[1];
    sz = 2'h2;
    e = 3'h2;
    case (op)
      0, 1, 2, 3: begin
        w = {4'h5, op[0], op[1], 1'b1, ro, rb, rd};
        a = rg[rb] + rg[ro];
        st = op == 4'h0;
        sz = op == 4'h2 ? 2'h0 : 2'h1;
        e = op == 4'h1 ? 3'h1 : op == 4'h2 ? 3'h3 : 3'h4;
        d = {16'h0000, d[15:0]};
      end
      4, 5, 6, 7: begin
        w = {3'h3, op[0], op[1], o5, rb, rd};
        a = rg[rb] + (op[0] ? {27'h0, o5} : {25'h0, o5, 2'h0});
        sz = op[0] ? 2'h0 : 2'h2;
        e = op[0] ? 3'h0 : 3'h2;
        if (op[0]) d = {24'h000000, d[7:0]};
      end
      8, 9: begin
        w = {4'h8, op[0], o5, rb, rd};
        a = rg[rb] + {26'h0, o5, 1'h0};
        st = !op[0];
        sz = 2'h1;
        e = 3'h1;
        d = {16'h0000, d[15:0]};
      end
      10, 11: begin
        w = {4'h9, op[0], rd, w8};
        a = sv + {22'h0, w8, 2'h0};
        st = !op[0];
      end
      12, 13: begin
        w = {4'hA, op[0], rd, w8};
        r = (op[0] ? sv : (pc + 32'h00000004) & 32'hFFFFFFFD) + {22'h0, w8, 2'h0};
      end
      default: w = 16'h5000;
    endcase
    if (op > 4'hD) begin
      instr_valid_in <= 1'b1;
      instr_in <= w;
      @(negedge mclk_in);
      chk1(instr_reject_out && !busy_out, "reject");
      @(posedge mclk_in);
      instr_valid_in <= 1'b0;
      @(posedge mclk_in);
    end else begin
      if (op < 4'hC) mq.push_back({st, sz, a, d});
      if (op < 4'hC) r = ext(u_pt.pat(a), e);
      if (op > 4'hB || !st) rq.push_back({rd, r});
      if (op > 4'hB || !st) rg[rd] = r;
      issue(w, hold);
    end
  endtask
  task conclude;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    #500000;
    fail("timeout");
    conclude();
  end
  // Main sequence
  initial begin
    x = $urandom(90);
    for (i = 0; i < 8; i = i + 1) begin
      rg[i] = $urandom;
      u_pt.regs[i] = rg[i];
    end
    repeat (4) @(posedge mclk_in);
    resetn_in <= 1'b1;
    @(posedge mclk_in);
    for (i = 0; i < 15; i = i + 1) run(i[3:0], 1'b1, i == 12);
    $display("test directed done");
    for (i = 0; i < 300; i = i + 1) run(4'($urandom % 15), 1'b0, 1'b0);
    $display("test random done");
    repeat (4) @(posedge mclk_in);
    chk1(rq.size() == 0 && mq.size() == 0, "results missing");
    resetn_in <= 1'b0;
    @(negedge mclk_in);
    chk1(instr_ready_out && !busy_out && !rf_we_out && !mem_req_out, "reset state");
    $display("test reset done");
    conclude();
  end
endmodule
